// *** core/legacy_decode_pkg.sv ***
package legacy_decode_pkg;

	// ---------------------------------------------
	// Widths
	// ---------------------------------------------
	localparam int ADDR_W = 36;
	localparam int APB_AW = 8;

	// ---------------------------------------------
	// Register offsets
	// ---------------------------------------------
	localparam logic [7:0] OFS_BRIDGE_CONTROL = 8'h00;
	localparam logic [7:0] OFS_HUB_CONFIG = 8'h04;
	localparam logic [7:0] OFS_SMM_RAM_CONTROL = 8'h08;
	localparam logic [7:0] OFS_EXT_SMM_CONTROL = 8'h0C;
	localparam logic [7:0] OFS_TOP_LOW_MEMORY = 8'h10;
	localparam logic [7:0] OFS_FIXED_HOLE = 8'h14;
	localparam logic [7:0] OFS_SHADOW_EXPANSION = 8'h18;
	localparam logic [7:0] OFS_SHADOW_BIOS = 8'h1C;
	localparam logic [7:0] OFS_DECODE_STATUS = 8'h20;
	localparam logic [7:0] OFS_DECODE_COUNT = 8'h24;

	// ---------------------------------------------
	// Field positions
	// ---------------------------------------------
	localparam int VGA_EN_LSB = 0;
	localparam int MONO_BIT = 0;
	localparam int DUAL_BIT = 1;
	localparam int SMM_EN_BIT = 0;
	localparam int SMM_OPEN_BIT = 1;
	localparam int TOP_SEGMENT_SMM_EN_BIT = 0;
	localparam int TOP_SEGMENT_SIZE_LSB = 1;
	localparam int HOLE_BIT = 0;
	localparam int EXT_ATTR_LSB = 0;
	localparam int BIOS_ATTR_LSB = 8;
	localparam int ATTR_RD_BIT = 0;
	localparam int ATTR_WR_BIT = 1;

	// ---------------------------------------------
	// Reset values
	// ---------------------------------------------
	localparam logic [2:0] VGA_EN_RST = 3'h0;
	localparam logic [15:0] TOP_LOW_MEMORY_BOUNDARY_RST = 16'h1000;
	localparam logic [15:0] EXP_ATTR_RST = 16'h0000;
	localparam logic [7:0] EXT_ATTR_RST = 8'h00;
	localparam logic [1:0] BIOS_ATTR_RST = 2'h0;
	localparam logic [1:0] TOP_SEGMENT_SIZE_RST = 2'h0;

	// ---------------------------------------------
	// Address map
	// ---------------------------------------------
	localparam logic [ADDR_W-1:0] VIDEO_BASE = 36'h0_000A_0000;
	localparam logic [ADDR_W-1:0] MONO_BASE = 36'h0_000B_0000;
	localparam logic [ADDR_W-1:0] MONO_END = 36'h0_000B_7FFF;
	localparam logic [ADDR_W-1:0] SHADOW_BASE = 36'h0_000C_0000;
	localparam logic [ADDR_W-1:0] EXT_BIOS_BASE = 36'h0_000E_0000;
	localparam logic [ADDR_W-1:0] SYS_BIOS_BASE = 36'h0_000F_0000;
	localparam logic [ADDR_W-1:0] ONE_MB = 36'h0_0010_0000;
	localparam logic [ADDR_W-1:0] HOLE_BASE = 36'h0_00F0_0000;
	localparam logic [ADDR_W-1:0] HOLE_END = 36'h0_00FF_FFFF;
	localparam logic [ADDR_W-1:0] FOUR_GB = 36'h1_0000_0000;
	localparam logic [ADDR_W-1:0] LIMIT_DUAL = 36'h3_FC00_0000;
	localparam logic [ADDR_W-1:0] LIMIT_SINGLE = 36'h1_FE00_0000;
	localparam logic [ADDR_W-1:0] TOP_SEGMENT_SMM_MIN = 36'h0_0002_0000;
	localparam logic [ADDR_W-1:0] IO_END = 36'h0_0001_0003;

	// ---------------------------------------------
	// Types
	// ---------------------------------------------
	typedef enum logic [2:0] {TGT_SYSMEM, TGT_PORT_A, TGT_PORT_B, TGT_PORT_C,
		TGT_PORT_D, TGT_SPECIAL, TGT_ABORT} target_type;
	typedef enum logic [2:0] {SRC_SYSBUS, SRC_HUB_A, SRC_HUB_B, SRC_HUB_C,
		SRC_HUB_D} source_type;

	// ---------------------------------------------
	// Helpers
	// ---------------------------------------------
	function automatic logic in_range(logic [ADDR_W-1:0] a, logic [ADDR_W-1:0] lo, logic [ADDR_W-1:0] hi);
		return (a >= lo) && (a <= hi);
	endfunction : in_range

	function automatic logic mono_io_port(logic [ADDR_W-1:0] a);
		return (a == 36'h3B4) || (a == 36'h3B5) || (a == 36'h3B8) ||
			(a == 36'h3B9) || (a == 36'h3BA) || (a == 36'h3BF);
	endfunction : mono_io_port

	// Attribute pair: read bit and write bit select memory when set
	function automatic logic attr_to_mem(logic [1:0] attr, logic is_write);
		return is_write ? attr[ATTR_WR_BIT] : attr[ATTR_RD_BIT];
	endfunction : attr_to_mem

endpackage : legacy_decode_pkg

// *** core/decode_cfg_if.sv ***
`timescale 1ns/10ps
interface decode_cfg_if;
	logic [2:0] vga_route_enable;
	logic mono_adapter_to_primary;
	logic dual_channel;
	logic smm_global_enable;
	logic smm_space_open;
	logic top_segment_enable;
	logic [1:0] top_segment_size;
	logic [15:0] top_low_memory_boundary;
	logic isa_hole_enable;
	logic [15:0] expansion_attr;
	logic [7:0] ext_bios_attr;
	logic [1:0] sys_bios_attr;

	modport regs (output vga_route_enable, mono_adapter_to_primary, dual_channel, smm_global_enable,
		smm_space_open, top_segment_enable, top_segment_size, top_low_memory_boundary,
		isa_hole_enable, expansion_attr, ext_bios_attr, sys_bios_attr);
	modport dec (input vga_route_enable, mono_adapter_to_primary, dual_channel, smm_global_enable,
		smm_space_open, top_segment_enable, top_segment_size, top_low_memory_boundary,
		isa_hole_enable, expansion_attr, ext_bios_attr, sys_bios_attr);
endinterface : decode_cfg_if

// *** core/route_decoder.sv ***
`timescale 1ns/10ps
module route_decoder
	import legacy_decode_pkg::*;
(
	// Configuration
	decode_cfg_if.dec cfg,
	// Request
	input wire logic [legacy_decode_pkg::ADDR_W-1:0] addr,
	input wire logic is_io,
	input wire logic is_write,
	input wire logic smm_code,
	input wire legacy_decode_pkg::source_type source,
	// Result
	output legacy_decode_pkg::target_type target
);

	logic hub;
	logic smm_hit;
	logic [ADDR_W-1:0] top_low_memory_boundary_a;
	logic [ADDR_W-1:0] top_segment_smm_lo;
	logic [ADDR_W-1:0] mem_limit;
	target_type vga_tgt;

	// ---------------------------------------------
	// Address decode
	// ---------------------------------------------
	always_comb begin
		hub = (source != SRC_SYSBUS);
		smm_hit = cfg.smm_global_enable && (cfg.smm_space_open || smm_code);
		top_low_memory_boundary_a = ADDR_W'({cfg.top_low_memory_boundary, 16'h0000});
		top_segment_smm_lo = top_low_memory_boundary_a - (TOP_SEGMENT_SMM_MIN << cfg.top_segment_size);
		mem_limit = cfg.dual_channel ? LIMIT_DUAL : LIMIT_SINGLE;
		// Lowest bridge wins if software breaks the one-bridge limit
		if (cfg.vga_route_enable[0]) begin
			vga_tgt = TGT_PORT_B;
		end else if (cfg.vga_route_enable[1]) begin
			vga_tgt = TGT_PORT_C;
		end else if (cfg.vga_route_enable[2]) begin
			vga_tgt = TGT_PORT_D;
		end else begin
			vga_tgt = TGT_PORT_A;
		end
		target = TGT_PORT_A;
		if (is_io) begin
			if (hub || addr >= IO_END) begin
				target = TGT_ABORT;
			end else if (cfg.mono_adapter_to_primary && mono_io_port(addr)) begin
				target = TGT_PORT_A;
			end else begin
				target = TGT_PORT_A;
			end
		end else if (addr >= mem_limit) begin
			target = TGT_ABORT;
		end else if (addr >= FOUR_GB) begin
			target = TGT_SYSMEM;
		end else if (addr < VIDEO_BASE) begin
			target = TGT_SYSMEM;
		end else if (addr < SHADOW_BASE) begin
			if (hub && cfg.smm_global_enable) begin
				target = TGT_SPECIAL;
			end else if (!hub && smm_hit) begin
				target = TGT_SYSMEM;
			end else if (cfg.mono_adapter_to_primary && in_range(addr, MONO_BASE, MONO_END)) begin
				target = TGT_PORT_A;
			end else begin
				target = vga_tgt;
			end
		end else if (addr < ONE_MB) begin
			if (hub) begin
				target = TGT_SYSMEM;
			end else if (addr < EXT_BIOS_BASE) begin
				target = attr_to_mem(cfg.expansion_attr[{addr[16:14], 1'b0} +: 2], is_write)
					? TGT_SYSMEM : TGT_PORT_A;
			end else if (addr < SYS_BIOS_BASE) begin
				target = attr_to_mem(cfg.ext_bios_attr[{addr[15:14], 1'b0} +: 2], is_write)
					? TGT_SYSMEM : TGT_PORT_A;
			end else begin
				target = attr_to_mem(cfg.sys_bios_attr, is_write) ? TGT_SYSMEM : TGT_PORT_A;
			end
		end else if (cfg.isa_hole_enable && in_range(addr, HOLE_BASE, HOLE_END)) begin
			target = TGT_PORT_A;
		end else if (addr >= top_low_memory_boundary_a) begin
			target = TGT_PORT_A;
		end else if (addr >= top_segment_smm_lo && cfg.smm_global_enable && cfg.top_segment_enable) begin
			if (!hub && smm_hit) begin
				target = TGT_SYSMEM;
			end else begin
				target = TGT_SPECIAL;
			end
		end else begin
			target = TGT_SYSMEM;
		end
	end

endmodule : route_decoder

// *** core/legacy_memory_address_decoder.sv ***
// Decided for this implementation: the placing of the registers and the APB slave port.
`timescale 1ns/10ps
module legacy_memory_address_decoder
	import legacy_decode_pkg::*;
(
	// Clock and reset
	input wire logic core_clk,
	input wire logic rstn,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [legacy_decode_pkg::APB_AW-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Request
	input wire logic req_valid,
	input wire logic [legacy_decode_pkg::ADDR_W-1:0] req_addr,
	input wire logic req_write,
	input wire logic req_io,
	input wire logic req_smm_code,
	input wire legacy_decode_pkg::source_type req_source,
	// Routed result
	output logic route_valid,
	output legacy_decode_pkg::target_type route_target,
	output logic [legacy_decode_pkg::ADDR_W-1:0] route_addr,
	output logic route_write,
	output logic route_read_zero,
	output logic route_write_drop
);

	decode_cfg_if cfg_bus ();

	// ---------------------------------------------
	// Configuration state
	// ---------------------------------------------
	logic [2:0] vga_en_r, vga_en_nxt;
	logic mono_r, mono_nxt;
	logic dual_r, dual_nxt;
	logic smm_en_r, smm_en_nxt;
	logic smm_open_r, smm_open_nxt;
	logic top_segment_smm_en_r, top_segment_smm_en_nxt;
	logic [1:0] top_segment_size_r, top_segment_size_nxt;
	logic [15:0] top_low_memory_boundary_r, top_low_memory_boundary_nxt;
	logic hole_r, hole_nxt;
	logic [15:0] exp_attr_r, exp_attr_nxt;
	logic [7:0] ext_attr_r, ext_attr_nxt;
	logic [1:0] bios_attr_r, bios_attr_nxt;

	// ---------------------------------------------
	// Bus and result state
	// ---------------------------------------------
	logic [31:0] rdata_r, rdata_nxt;
	logic err_r, err_nxt;
	logic valid_r, valid_nxt;
	target_type tgt_r, tgt_nxt;
	logic [ADDR_W-1:0] addr_r, addr_nxt;
	logic wr_r, wr_nxt;
	logic zero_r, zero_nxt;
	logic drop_r, drop_nxt;
	target_type last_r, last_nxt;
	logic [15:0] special_cnt_r, special_cnt_nxt;
	logic [15:0] abort_cnt_r, abort_cnt_nxt;

	logic wr_access;
	logic setup;
	logic mapped;
	target_type dec_target;

	// ---------------------------------------------
	// Decoder
	// ---------------------------------------------
	assign cfg_bus.vga_route_enable = vga_en_r;
	assign cfg_bus.mono_adapter_to_primary = mono_r;
	assign cfg_bus.dual_channel = dual_r;
	assign cfg_bus.smm_global_enable = smm_en_r;
	assign cfg_bus.smm_space_open = smm_open_r;
	assign cfg_bus.top_segment_enable = top_segment_smm_en_r;
	assign cfg_bus.top_segment_size = top_segment_size_r;
	assign cfg_bus.top_low_memory_boundary = top_low_memory_boundary_r;
	assign cfg_bus.isa_hole_enable = hole_r;
	assign cfg_bus.expansion_attr = exp_attr_r;
	assign cfg_bus.ext_bios_attr = ext_attr_r;
	assign cfg_bus.sys_bios_attr = bios_attr_r;

	route_decoder u_dec (
		.cfg(cfg_bus.dec),
		.addr(req_addr),
		.is_io(req_io),
		.is_write(req_write),
		.smm_code(req_smm_code),
		.source(req_source),
		.target(dec_target)
	);

	// ---------------------------------------------
	// APB decode
	// ---------------------------------------------
	// Zero wait states: every access completes in its first access cycle
	assign pready = 1'b1;
	assign prdata = rdata_r;
	assign pslverr = err_r;
	assign setup = psel && !penable;
	assign wr_access = psel && penable && pwrite;

	always_comb begin
		unique case (paddr)
			OFS_BRIDGE_CONTROL, OFS_HUB_CONFIG, OFS_SMM_RAM_CONTROL, OFS_EXT_SMM_CONTROL,
			OFS_TOP_LOW_MEMORY, OFS_FIXED_HOLE, OFS_SHADOW_EXPANSION, OFS_SHADOW_BIOS,
			OFS_DECODE_STATUS, OFS_DECODE_COUNT: begin
				mapped = 1'b1;
			end
			default: begin
				mapped = 1'b0;
			end
		endcase
	end

	// ---------------------------------------------
	// Configuration registers
	// ---------------------------------------------
	always_comb begin
		vga_en_nxt = vga_en_r;
		mono_nxt = mono_r;
		dual_nxt = dual_r;
		smm_en_nxt = smm_en_r;
		smm_open_nxt = smm_open_r;
		top_segment_smm_en_nxt = top_segment_smm_en_r;
		top_segment_size_nxt = top_segment_size_r;
		top_low_memory_boundary_nxt = top_low_memory_boundary_r;
		hole_nxt = hole_r;
		exp_attr_nxt = exp_attr_r;
		ext_attr_nxt = ext_attr_r;
		bios_attr_nxt = bios_attr_r;
		if (wr_access) begin
			unique case (paddr)
				OFS_BRIDGE_CONTROL: begin
					vga_en_nxt = pwdata[VGA_EN_LSB +: 3];
				end
				OFS_HUB_CONFIG: begin
					mono_nxt = pwdata[MONO_BIT];
					dual_nxt = pwdata[DUAL_BIT];
				end
				OFS_SMM_RAM_CONTROL: begin
					smm_en_nxt = pwdata[SMM_EN_BIT];
					smm_open_nxt = pwdata[SMM_OPEN_BIT];
				end
				OFS_EXT_SMM_CONTROL: begin
					top_segment_smm_en_nxt = pwdata[TOP_SEGMENT_SMM_EN_BIT];
					top_segment_size_nxt = pwdata[TOP_SEGMENT_SIZE_LSB +: 2];
				end
				OFS_TOP_LOW_MEMORY: begin
					top_low_memory_boundary_nxt = pwdata[31:16];
				end
				OFS_FIXED_HOLE: begin
					hole_nxt = pwdata[HOLE_BIT];
				end
				OFS_SHADOW_EXPANSION: begin
					exp_attr_nxt = pwdata[15:0];
				end
				OFS_SHADOW_BIOS: begin
					ext_attr_nxt = pwdata[EXT_ATTR_LSB +: 8];
					bios_attr_nxt = pwdata[BIOS_ATTR_LSB +: 2];
				end
				default: begin
				end
			endcase
		end
	end

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			vga_en_r <= VGA_EN_RST;
			mono_r <= 1'b0;
			dual_r <= 1'b0;
			smm_en_r <= 1'b0;
			smm_open_r <= 1'b0;
			top_segment_smm_en_r <= 1'b0;
			top_segment_size_r <= TOP_SEGMENT_SIZE_RST;
			top_low_memory_boundary_r <= TOP_LOW_MEMORY_BOUNDARY_RST;
			hole_r <= 1'b0;
			exp_attr_r <= EXP_ATTR_RST;
			ext_attr_r <= EXT_ATTR_RST;
			bios_attr_r <= BIOS_ATTR_RST;
		end else begin
			vga_en_r <= vga_en_nxt;
			mono_r <= mono_nxt;
			dual_r <= dual_nxt;
			smm_en_r <= smm_en_nxt;
			smm_open_r <= smm_open_nxt;
			top_segment_smm_en_r <= top_segment_smm_en_nxt;
			top_segment_size_r <= top_segment_size_nxt;
			top_low_memory_boundary_r <= top_low_memory_boundary_nxt;
			hole_r <= hole_nxt;
			exp_attr_r <= exp_attr_nxt;
			ext_attr_r <= ext_attr_nxt;
			bios_attr_r <= bios_attr_nxt;
		end
	end

	// ---------------------------------------------
	// Read data, captured in the setup cycle
	// ---------------------------------------------
	always_comb begin
		rdata_nxt = rdata_r;
		err_nxt = 1'b0;
		if (setup) begin
			err_nxt = !mapped;
			rdata_nxt = 32'h0000_0000;
			unique case (paddr)
				OFS_BRIDGE_CONTROL: rdata_nxt[VGA_EN_LSB +: 3] = vga_en_r;
				OFS_HUB_CONFIG: begin
					rdata_nxt[MONO_BIT] = mono_r;
					rdata_nxt[DUAL_BIT] = dual_r;
				end
				OFS_SMM_RAM_CONTROL: begin
					rdata_nxt[SMM_EN_BIT] = smm_en_r;
					rdata_nxt[SMM_OPEN_BIT] = smm_open_r;
				end
				OFS_EXT_SMM_CONTROL: begin
					rdata_nxt[TOP_SEGMENT_SMM_EN_BIT] = top_segment_smm_en_r;
					rdata_nxt[TOP_SEGMENT_SIZE_LSB +: 2] = top_segment_size_r;
				end
				OFS_TOP_LOW_MEMORY: rdata_nxt[31:16] = top_low_memory_boundary_r;
				OFS_FIXED_HOLE: rdata_nxt[HOLE_BIT] = hole_r;
				OFS_SHADOW_EXPANSION: rdata_nxt[15:0] = exp_attr_r;
				OFS_SHADOW_BIOS: begin
					rdata_nxt[EXT_ATTR_LSB +: 8] = ext_attr_r;
					rdata_nxt[BIOS_ATTR_LSB +: 2] = bios_attr_r;
				end
				OFS_DECODE_STATUS: rdata_nxt[2:0] = last_r;
				OFS_DECODE_COUNT: rdata_nxt = {abort_cnt_r, special_cnt_r};
				default: begin
				end
			endcase
		end
	end

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			rdata_r <= 32'h0000_0000;
			err_r <= 1'b0;
		end else begin
			rdata_r <= rdata_nxt;
			err_r <= err_nxt;
		end
	end

	// ---------------------------------------------
	// Routed result, one cycle after the request
	// ---------------------------------------------
	always_comb begin
		valid_nxt = req_valid;
		tgt_nxt = req_valid ? dec_target : tgt_r;
		addr_nxt = req_valid ? req_addr : addr_r;
		wr_nxt = req_valid ? req_write : wr_r;
		zero_nxt = req_valid && dec_target == TGT_SPECIAL && !req_write;
		drop_nxt = req_valid && dec_target == TGT_SPECIAL && req_write;
		last_nxt = req_valid ? dec_target : last_r;
		special_cnt_nxt = special_cnt_r;
		abort_cnt_nxt = abort_cnt_r;
		// Clearing write first, so an event in the same cycle still counts
		if (wr_access && paddr == OFS_DECODE_COUNT) begin
			special_cnt_nxt = 16'h0000;
			abort_cnt_nxt = 16'h0000;
		end
		// Counters saturate rather than wrap to keep them meaningful
		if (req_valid && dec_target == TGT_SPECIAL && special_cnt_nxt != 16'hFFFF) begin
			special_cnt_nxt = special_cnt_nxt + 16'h0001;
		end
		if (req_valid && dec_target == TGT_ABORT && abort_cnt_nxt != 16'hFFFF) begin
			abort_cnt_nxt = abort_cnt_nxt + 16'h0001;
		end
	end

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			valid_r <= 1'b0;
			tgt_r <= TGT_PORT_A;
			addr_r <= '0;
			wr_r <= 1'b0;
			zero_r <= 1'b0;
			drop_r <= 1'b0;
			last_r <= TGT_PORT_A;
			special_cnt_r <= 16'h0000;
			abort_cnt_r <= 16'h0000;
		end else begin
			valid_r <= valid_nxt;
			tgt_r <= tgt_nxt;
			addr_r <= addr_nxt;
			wr_r <= wr_nxt;
			zero_r <= zero_nxt;
			drop_r <= drop_nxt;
			last_r <= last_nxt;
			special_cnt_r <= special_cnt_nxt;
			abort_cnt_r <= abort_cnt_nxt;
		end
	end

	assign route_valid = valid_r;
	assign route_target = tgt_r;
	assign route_addr = addr_r;
	assign route_write = wr_r;
	assign route_read_zero = zero_r;
	assign route_write_drop = drop_r;

endmodule : legacy_memory_address_decoder

// *** test/legacy_decode_assertions.sv ***
`timescale 1ns/10ps
module legacy_decode_assertions
	import legacy_decode_pkg::*;
(
	// Clock and reset
	input wire logic core_clk,
	input wire logic rstn,
	// APB
	input wire logic psel,
	input wire logic penable,
	input wire logic [legacy_decode_pkg::APB_AW-1:0] paddr,
	input wire logic pslverr,
	// Request
	input wire logic req_valid,
	input wire logic [legacy_decode_pkg::ADDR_W-1:0] req_addr,
	input wire logic req_write,
	input wire logic req_io,
	input wire legacy_decode_pkg::source_type req_source,
	// Result
	input wire logic route_valid,
	input wire legacy_decode_pkg::target_type route_target,
	input wire logic [legacy_decode_pkg::ADDR_W-1:0] route_addr,
	input wire logic route_write,
	input wire logic route_read_zero,
	input wire logic route_write_drop
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rstn);

	// ---------------------------------------------
	// Sequences
	// ---------------------------------------------
	sequence mem_req_s;
		req_valid && !req_io;
	endsequence
	sequence hub_mem_s;
		mem_req_s ##0 req_source != SRC_SYSBUS;
	endsequence

	// ---------------------------------------------
	// Properties
	// ---------------------------------------------
	low_mem_a: assert property (mem_req_s ##0 req_addr < VIDEO_BASE |=> route_target == TGT_SYSMEM)
		else $error("low memory not sent to system memory");
	mono_io_a: assert property (req_valid && req_io && req_source == SRC_SYSBUS &&
		req_addr inside {36'h3B4, 36'h3B5, 36'h3B8, 36'h3B9, 36'h3BA, 36'h3BF} |=> route_target == TGT_PORT_A)
		else $error("monochrome port cycle not sent to port a");
	hub_shadow_a: assert property (hub_mem_s ##0 req_addr >= SHADOW_BASE && req_addr < ONE_MB
		|=> route_target == TGT_SYSMEM) else $error("hub shadow access not sent to memory");
	hub_video_a: assert property (hub_mem_s ##0 req_addr >= VIDEO_BASE && req_addr < SHADOW_BASE
		|=> route_target != TGT_SYSMEM) else $error("hub access reached smm video memory");
	high_mem_a: assert property (mem_req_s ##0 req_addr >= FOUR_GB && req_addr < LIMIT_SINGLE
		|=> route_target == TGT_SYSMEM) else $error("high memory not sent to memory");
	over_limit_a: assert property (mem_req_s ##0 req_addr >= LIMIT_DUAL |=> route_target == TGT_ABORT)
		else $error("memory above limit not aborted");
	io_limit_a: assert property (req_valid && req_io && req_addr >= IO_END |=> route_target == TGT_ABORT)
		else $error("io above limit not aborted");
	special_term_a: assert property (route_read_zero || route_write_drop |-> route_valid &&
		route_target == TGT_SPECIAL && route_read_zero == !route_write && route_write_drop == route_write)
		else $error("special termination flags wrong");
	route_pulse_a: assert property (req_valid |=> route_valid && route_addr == $past(req_addr) &&
		route_write == $past(req_write) ##1 !route_valid || $past(req_valid))
		else $error("routed result not one cycle after request");
	unmapped_err_a: assert property (psel && penable && paddr > 8'h24 |-> pslverr)
		else $error("unmapped register without slave error");
endmodule : legacy_decode_assertions

// *** test/route_sink.sv ***
`timescale 1ns/10ps
module route_sink
	import legacy_decode_pkg::*;
(
	// Clock and reset
	input wire logic core_clk,
	input wire logic rstn,
	// Routed result
	input wire logic route_valid,
	input wire legacy_decode_pkg::target_type route_target,
	// Capture
	output legacy_decode_pkg::target_type last_target
);
	// Abort after reset, so a missing first route cannot match its expected target; later ones can match the previous target
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			last_target <= TGT_ABORT;
		end else if (route_valid) begin
			last_target <= route_target;
		end
	end
endmodule : route_sink

// *** test/legacy_memory_address_decoder_tb.sv ***
`timescale 1ns/10ps
module legacy_memory_address_decoder_tb;
	import legacy_decode_pkg::*;
	logic core_clk = 1'b0;
	logic rstn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic req_valid = 1'b0;
	logic [35:0] req_addr = 36'h0;
	logic req_write = 1'b0;
	logic req_io = 1'b0;
	logic req_smm_code = 1'b0;
	source_type req_source = SRC_SYSBUS;
	logic route_valid, route_write, route_read_zero, route_write_drop;
	target_type route_target, last_target;
	logic [35:0] route_addr;
	logic [31:0] rd;
	logic err;
	int miscompares = 0;
	int n_checks = 0;

	always #2 core_clk = ~core_clk;

	legacy_memory_address_decoder u_dut (.core_clk(core_clk), .rstn(rstn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.req_valid(req_valid), .req_addr(req_addr), .req_write(req_write), .req_io(req_io),
		.req_smm_code(req_smm_code), .req_source(req_source), .route_valid(route_valid),
		.route_target(route_target), .route_addr(route_addr), .route_write(route_write),
		.route_read_zero(route_read_zero), .route_write_drop(route_write_drop));
	route_sink u_sink (.core_clk(core_clk), .rstn(rstn), .route_valid(route_valid),
		.route_target(route_target), .last_target(last_target));

	// ---------------------------------------------
	// Tasks
	// ---------------------------------------------
	task check(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("ERROR at %0t: got %0h expected %0h", $time, got, exp);
		end
	endtask : check

	task wrap_up;
		$display("checks %0d miscompares %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask : wrap_up

	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge core_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		do @(posedge core_clk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask : wr

	task rdchk(input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		check(rd, exp);
	endtask : rdchk

	task route(input logic [35:0] a, input logic w, input logic io, input logic sm, input source_type s,
		input target_type e);
		@(posedge core_clk);
		req_valid <= 1'b1;
		req_addr <= a;
		req_write <= w;
		req_io <= io;
		req_smm_code <= sm;
		req_source <= s;
		@(posedge core_clk);
		req_valid <= 1'b0;
		#1;
		// Result pulse and special flags stand for this one cycle only
		check({29'h0, route_valid, route_read_zero, route_write_drop},
			{29'h0, 1'b1, e == TGT_SPECIAL && !w, e == TGT_SPECIAL && w});
		// Sink takes the target at the edge that ends the pulse
		@(posedge core_clk);
		#1;
		check(32'(last_target), 32'(e));
	endtask : route

	task mrd(input logic [35:0] a, input target_type e);
		route(a, 1'b0, 1'b0, 1'b0, SRC_SYSBUS, e);
	endtask : mrd

	task mwr(input logic [35:0] a, input target_type e);
		route(a, 1'b1, 1'b0, 1'b0, SRC_SYSBUS, e);
	endtask : mwr

	// ---------------------------------------------
	// Tests
	// ---------------------------------------------
	logic [35:0] mono_ports [6] = '{36'h3B4, 36'h3B5, 36'h3B8, 36'h3B9, 36'h3BA, 36'h3BF};

	initial begin
		repeat (5) @(posedge core_clk);
		rstn <= 1'b1;
		rdchk(OFS_BRIDGE_CONTROL, 32'h0);
		rdchk(OFS_TOP_LOW_MEMORY, 32'h1000_0000);
		rdchk(OFS_SHADOW_BIOS, 32'h0);
		apb(1'b0, 8'h28, 32'h0);
		check({31'h0, err}, 32'h1);
		check(rd, 32'h0);
		mrd(36'h0_0009_FFFF, TGT_SYSMEM);
		mrd(VIDEO_BASE, TGT_PORT_A);
		mwr(SYS_BIOS_BASE, TGT_PORT_A);
		for (int i = 0; i < 3; i++) begin
			wr(OFS_BRIDGE_CONTROL, 32'h1 << i);
			mrd(MONO_BASE, target_type'(3'(i + 2)));
		end
		wr(OFS_HUB_CONFIG, 32'h1);
		mrd(MONO_BASE, TGT_PORT_A);
		mrd(36'h0_000B_8000, TGT_PORT_D);
		for (int i = 0; i < 6; i++) route(mono_ports[i], 1'b0, 1'b1, 1'b0, SRC_SYSBUS, TGT_PORT_A);
		wr(OFS_SMM_RAM_CONTROL, 32'h1);
		mrd(VIDEO_BASE, TGT_PORT_D);
		route(MONO_BASE, 1'b0, 1'b0, 1'b1, SRC_SYSBUS, TGT_SYSMEM);
		wr(OFS_SMM_RAM_CONTROL, 32'h3);
		mrd(MONO_BASE, TGT_SYSMEM);
		route(VIDEO_BASE, 1'b1, 1'b0, 1'b0, SRC_HUB_B, TGT_SPECIAL);
		wr(OFS_SHADOW_EXPANSION, 32'h800D);
		mrd(SHADOW_BASE, TGT_SYSMEM);
		mwr(SHADOW_BASE, TGT_PORT_A);
		mrd(36'h0_000D_C000, TGT_PORT_A);
		mwr(36'h0_000D_C000, TGT_SYSMEM);
		mrd(36'h0_000C_8000, TGT_PORT_A);
		mrd(36'h0_000C_4000, TGT_SYSMEM);
		route(36'h0_000C_4000, 1'b1, 1'b0, 1'b0, SRC_HUB_C, TGT_SYSMEM);
		wr(OFS_SHADOW_BIOS, 32'h3C0);
		rdchk(OFS_SHADOW_BIOS, 32'h3C0);
		mwr(36'h0_000E_C000, TGT_SYSMEM);
		mrd(EXT_BIOS_BASE, TGT_PORT_A);
		mrd(SYS_BIOS_BASE, TGT_SYSMEM);
		mrd(HOLE_BASE, TGT_SYSMEM);
		wr(OFS_FIXED_HOLE, 32'h1);
		mrd(HOLE_END, TGT_PORT_A);
		mrd(36'h0_0100_0000, TGT_SYSMEM);
		wr(OFS_EXT_SMM_CONTROL, 32'h1);
		mrd(36'h0_0FFE_0000, TGT_SYSMEM);
		route(36'h0_0FFE_0000, 1'b0, 1'b0, 1'b0, SRC_HUB_D, TGT_SPECIAL);
		mrd(36'h0_0FFD_FFFF, TGT_SYSMEM);
		wr(OFS_SMM_RAM_CONTROL, 32'h1);
		mrd(36'h0_0FFE_0000, TGT_SPECIAL);
		route(36'h0_0FFE_0000, 1'b0, 1'b0, 1'b1, SRC_SYSBUS, TGT_SYSMEM);
		wr(OFS_EXT_SMM_CONTROL, 32'h7);
		rdchk(OFS_EXT_SMM_CONTROL, 32'h7);
		mwr(36'h0_0FF0_0000, TGT_SPECIAL);
		mrd(36'h0_0FEF_FFFF, TGT_SYSMEM);
		mrd(36'h0_1000_0000, TGT_PORT_A);
		mrd(36'h1_FDFF_FFFF, TGT_SYSMEM);
		mrd(LIMIT_SINGLE, TGT_ABORT);
		wr(OFS_HUB_CONFIG, 32'h3);
		mrd(LIMIT_SINGLE, TGT_SYSMEM);
		mrd(LIMIT_DUAL, TGT_ABORT);
		route(IO_END, 1'b0, 1'b1, 1'b0, SRC_SYSBUS, TGT_ABORT);
		route(36'h0_0001_0002, 1'b0, 1'b1, 1'b0, SRC_SYSBUS, TGT_PORT_A);
		rdchk(OFS_DECODE_STATUS, 32'h1);
		rdchk(OFS_DECODE_COUNT, 32'h0003_0004);
		wr(OFS_DECODE_COUNT, 32'h0);
		rdchk(OFS_DECODE_COUNT, 32'h0);
		wrap_up();
	end

	// Whole run needs well under a thousand cycles
	initial begin
		repeat (20000) @(posedge core_clk);
		miscompares++;
		wrap_up();
	end
endmodule : legacy_memory_address_decoder_tb

bind legacy_memory_address_decoder legacy_decode_assertions u_chk (.core_clk(core_clk), .rstn(rstn),
	.psel(psel), .penable(penable), .paddr(paddr), .pslverr(pslverr), .req_valid(req_valid),
	.req_addr(req_addr), .req_write(req_write), .req_io(req_io), .req_source(req_source),
	.route_valid(route_valid), .route_target(route_target), .route_addr(route_addr),
	.route_write(route_write), .route_read_zero(route_read_zero), .route_write_drop(route_write_drop));
